// file: testbench.sv
/*
 Testbench: CPU and display traffic in fast, slow and SRAM operation,
 acquisition traffic in slow operation only. Assumes the checker binds itself into the design.
*/
`timescale 1ns/1ps
module testbench;
   import ttmi_pkg::*;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic slow_mode = 1'b0, sram_mode = 1'b0, cpu_req = 1'b0, cpu_we = 1'b0;
   logic acq_valid = 1'b0, acq_mac = 1'b0, disp_active = 1'b0, disp_req = 1'b0;
   logic [BADDR_W-1:0] cpu_addr = '0, acq_addr = '0, disp_addr = '0, mem_addr;
   logic [7:0] cpu_wdata = '0, acq_data = '0, cpu_rdata, disp_rdata;
   logic cpu_ack, acq_ready, disp_ack, mem_we_n, pin_data_o, pin_data_i, pin_data_oe_n;
   logic pin_ras_o, pin_ras_i, pin_ras_oe_n, pin_cas_o, pin_cas_i, pin_cas_oe_n, sram_dq_oe_n;
   logic [4:0] sram_dq_o, sram_dq_i;
   int error_cnt = 0;
   int checks = 0;
   logic [7:0] sb [logic [BADDR_W-1:0]];
   ttmi_top dut (.*);
   ttmi_mem_model mem (.*);
   always #5 clk_sys = ~clk_sys;
   // Byte last written to an address
   function automatic logic [7:0] exp_byte(input logic [BADDR_W-1:0] a);
      return sb.exists(a) ? sb[a] : 8'h00;
   endfunction
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // One client access, request held until its acknowledge
   task automatic acc(input bit dsp, input logic we, input logic [BADDR_W-1:0] a, input logic [7:0] d,
                      output logic [7:0] q);
      int n;
      @(posedge clk_sys);
      if (dsp) begin
         disp_addr <= a;
         disp_req <= 1'b1;
      end else begin
         cpu_we <= we;
         cpu_addr <= a;
         cpu_wdata <= d;
         cpu_req <= 1'b1;
      end
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while ((dsp ? disp_ack : cpu_ack) !== 1'b1 && n < 3000);
      q = dsp ? disp_rdata : cpu_rdata;
      cpu_req <= 1'b0;
      disp_req <= 1'b0;
      if (n >= 3000) begin
         error_cnt++;
         complete_run();
      end
   endtask
   // Random and corner bytes written by the CPU, read back by both clients
   task automatic rw_test(input string name);
      logic [BADDR_W-1:0] a [6];
      logic [7:0] q;
      a[0] = '0;
      a[1] = '1;
      for (int i = 0; i < 6; i++) begin
         if (i > 1) a[i] = BADDR_W'($urandom);
         sb[a[i]] = 8'($urandom);
         acc(1'b0, 1'b1, a[i], sb[a[i]], q);
      end
      for (int i = 0; i < 6; i++) begin
         acc(i[0], 1'b0, a[i], 8'h00, q);
         check(name, q, exp_byte(a[i])); // Read equals write
      end
      $display("test %s done", name);
   endtask
   // Slicer words held back during display, then released as packets
   task automatic acq_test();
      int n;
      logic [7:0] q;
      n = 0;
      disp_active <= 1'b1;
      @(posedge clk_sys);
      for (int i = 0; i < 12; i++) begin
         acq_addr <= BADDR_W'(21'h000100 + n);
         acq_data <= 8'($urandom);
         acq_valid <= 1'b1;
         @(posedge clk_sys);
         if (acq_ready === 1'b1) begin
            sb[acq_addr] = acq_data;
            n++;
         end
      end
      acq_valid <= 1'b0;
      check("acq_fill", 8'(n), 8'h08); // Nothing drained
      repeat (300) @(posedge clk_sys);
      check("acq_hold", {7'h00, acq_ready}, 8'h00); // Still held
      acq_mac <= 1'b1;
      for (int i = 0; i < n; i++) begin
         acc(1'b0, 1'b0, BADDR_W'(21'h000100 + i), 8'h00, q);
         check("acq_data", q, exp_byte(BADDR_W'(21'h000100 + i))); // Drained in order
      end
      disp_active <= 1'b0;
      acq_mac <= 1'b0;
      slow_mode <= 1'b0;
      $display("test acq done");
   endtask
   // Main sequence
   initial begin
      void'($urandom(78640));
      repeat (10) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rw_test("fast_dram");
      slow_mode <= 1'b1;
      rw_test("slow_dram");
      acq_test();
      resetn <= 1'b0;
      sram_mode <= 1'b1;
      repeat (3) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (3) @(posedge clk_sys);
      sb.delete();
      rw_test("sram"); // Same results through the adapter
      complete_run();
   end
   // Watchdog
   initial begin
      #400000;
      error_cnt++;
      complete_run();
   end
endmodule

// file: ttmi_chk.sv
/*
 Checker of strobe timing, pin use and client pacing.
 Assumes it is bound into ttmi_top and sees only its ports.
*/
`timescale 1ns/1ps
module ttmi_chk (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic slow_mode,
   input wire logic sram_mode,
   input wire logic cpu_req,
   input wire logic cpu_ack,
   input wire logic disp_req,
   input wire logic disp_ack,
   input wire logic [ttmi_pkg::BADDR_W-1:0] mem_addr,
   input wire logic mem_we_n,
   input wire logic pin_data_oe_n,
   input wire logic pin_ras_o,
   input wire logic pin_ras_oe_n,
   input wire logic pin_cas_o,
   input wire logic pin_cas_oe_n,
   input wire logic sram_dq_oe_n
);
   import ttmi_pkg::*;
   logic [8:0] wait_ff;
   logic [11:0] gap_ff;
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);
   // Cycles a CPU request has been held
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         wait_ff <= 9'h000;
      end else if (!cpu_req || cpu_ack) begin
         wait_ff <= 9'h000;
      end else if (wait_ff != 9'h1FF) begin
         wait_ff <= wait_ff + 9'h001;
      end
   end
   // Cycles since the last refresh in DRAM operation
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         gap_ff <= 12'h000;
      end else if (sram_mode || (!pin_cas_o && pin_ras_o)) begin
         gap_ff <= 12'h000;
      end else if (gap_ff != 12'hFFF) begin
         gap_ff <= gap_ff + 12'h001;
      end
   end
   sequence s_open;
      (pin_cas_o && !pin_ras_o) [*6] ##1 !pin_cas_o;
   endsequence
   sequence s_bit_fast;
      (!pin_cas_o) [*6] ##1 (pin_cas_o && !pin_ras_o) [*6] ##1 (pin_ras_o || !pin_cas_o);
   endsequence
   sequence s_bit_slow;
      (!pin_cas_o) [*8] ##1 (pin_cas_o && !pin_ras_o) [*8] ##1 pin_cas_o ##1 (pin_ras_o || !pin_cas_o);
   endsequence
   chk_cbr_order: assert property (!sram_mode && $fell(pin_cas_o) && pin_ras_o |=> !pin_ras_o)
      else $error("refresh row strobe late");
   chk_row_to_col: assert property (!sram_mode && $fell(pin_ras_o) && pin_cas_o |-> s_open)
      else $error("column strobe not 6 cycles after row");
   chk_page_fast: assert property (!sram_mode && !slow_mode && $fell(pin_cas_o) && !pin_ras_o |-> s_bit_fast)
      else $error("fast bit slot wrong");
   chk_page_slow: assert property (!sram_mode && slow_mode && $fell(pin_cas_o) && !pin_ras_o |-> s_bit_slow)
      else $error("slow bit slot wrong");
   chk_write_drive: assert property (!sram_mode && !pin_cas_o && !pin_ras_o && !mem_we_n |-> !pin_data_oe_n)
      else $error("data pin not driven in write");
   chk_dram_pins: assert property (!sram_mode && $past(resetn, 3) |-> !pin_ras_oe_n && !pin_cas_oe_n && sram_dq_oe_n
      && mem_addr[20:12] == 9'h000)
      else $error("DRAM pin use wrong");
   chk_sram_pins: assert property (sram_mode && $past(resetn, 3) |-> pin_data_oe_n == sram_dq_oe_n
      && pin_ras_oe_n == sram_dq_oe_n && pin_cas_oe_n == sram_dq_oe_n)
      else $error("SRAM data bits split");
   chk_disp_wait: assert property ($rose(disp_req) |-> ##[100:400] disp_ack)
      else $error("display fetch too slow");
   chk_ack_pace: assert property (cpu_ack |-> wait_ff >= (slow_mode ? 9'd148 : 9'd108))
      else $error("CPU access faster than allowed");
   chk_refresh_gap: assert property (gap_ff < REFRESH_CYC + 200)
      else $error("refresh missing");
endmodule
bind ttmi_top ttmi_chk u_chk (.*);

// file: ttmi_fifo.sv
/*
 Flip-flop FIFO with valid/ready on both sides, used in the acquisition
 write path. Assumes one clock and an active-low asynchronous reset that
 is already synchronised.
*/
`timescale 1ns/1ps
module ttmi_fifo #(
   parameter int WIDTH = 29,
   parameter int DEPTH = ttmi_pkg::ACQ_FIFO_DEPTH
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wr_ptr_ff;
   logic [AW-1:0] rd_ptr_ff;
   logic [AW:0] count_ff;
   logic push;
   logic pop;

   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
      $error("ttmi_fifo: DEPTH must be a power of two of at least 2");
   end

   // Honest full and empty from the fill count
   assign in_ready = count_ff != (AW + 1)'(DEPTH);
   assign out_valid = count_ff != '0;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem_ff[rd_ptr_ff];

   // Storage, one register per entry
   for (genvar i = 0; i < DEPTH; i++) begin : g_ent
      always_ff @(posedge clk_sys or negedge rst_n) begin
         if (!rst_n) begin
            mem_ff[i] <= '0;
         end else if (push && wr_ptr_ff == AW'(i)) begin
            mem_ff[i] <= in_data;
         end
      end
   end

   // Pointers and fill count
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff <= '0;
      end else begin
         if (push) begin
            wr_ptr_ff <= wr_ptr_ff + 1'b1;
         end
         if (pop) begin
            rd_ptr_ff <= rd_ptr_ff + 1'b1;
         end
         if (push && !pop) begin
            count_ff <= count_ff + 1'b1;
         end else if (pop && !push) begin
            count_ff <= count_ff - 1'b1;
         end
      end
   end
endmodule

// file: ttmi_mem_model.sv
/*
 Memory at the far side: 1-bit page-mode DRAM or byte-wide SRAM.
 Assumes the pins of ttmi_top and the device clock.
*/
`timescale 1ns/1ps
module ttmi_mem_model #(
   parameter int ACC_NS = 20
) (
   input wire logic clk_sys,
   input wire logic sram_mode,
   input wire logic [ttmi_pkg::BADDR_W-1:0] mem_addr,
   input wire logic mem_we_n,
   input wire logic pin_data_o,
   input wire logic pin_data_oe_n,
   input wire logic pin_ras_o,
   input wire logic pin_ras_oe_n,
   input wire logic pin_cas_o,
   input wire logic pin_cas_oe_n,
   input wire logic [4:0] sram_dq_o,
   input wire logic sram_dq_oe_n,
   output logic pin_data_i,
   output logic pin_ras_i,
   output logic pin_cas_i,
   output logic [4:0] sram_dq_i
);
   bit dram [0:16777215];
   bit [7:0] sram [0:2097151];
   logic [11:0] row = 12'h000;
   logic ras_q = 1'b1;
   logic cbr = 1'b0;
   logic last = 1'b0;
   logic [7:0] rd;
   wire cyc = !sram_mode && !pin_ras_o && !pin_cas_o && !cbr;
   wire [23:0] bix = {row, mem_addr[11:0]};
   wire [7:0] wr = {sram_dq_o[4:3], pin_cas_o, pin_ras_o, pin_data_o, sram_dq_o[2:0]};
   // Slow SRAM answers only after its access time
   assign #(ACC_NS) rd = sram[mem_addr];
   // Row latch, refresh detect and stores
   always @(posedge clk_sys) begin
      ras_q <= pin_ras_o;
      last <= pin_data_i;
      if (ras_q && !pin_ras_o) begin
         row <= mem_addr[11:0];
         cbr <= !pin_cas_o;
      end
      if (cyc && !mem_we_n) dram[bix] <= pin_data_o;
      if (sram_mode && !mem_we_n) sram[mem_addr] <= wr;
   end
   // Wire levels; an undriven data line toggles
   assign pin_data_i = !pin_data_oe_n ? pin_data_o : sram_mode ? rd[3] : cyc ? dram[bix] : ~last;
   assign pin_ras_i = !pin_ras_oe_n ? pin_ras_o : rd[4];
   assign pin_cas_i = !pin_cas_oe_n ? pin_cas_o : rd[5];
   assign sram_dq_i = !sram_dq_oe_n ? sram_dq_o : {rd[7:6], rd[2:0]};
endmodule

// file: ttmi_pkg.sv
/*
 Package of the teletext memory interface: bus widths, state and client
 codes, and all timing constants derived from the 100 MHz system clock.
 Assumes it is compiled before every other file of the block.
*/
package ttmi_pkg;
   // Clock and memory geometry
   localparam int CLK_MHZ = 100;
   localparam int MADDR_W = 12;
   localparam int BADDR_W = 21;
   localparam int SRAM_DQ_W = 8;
   localparam int ACQ_FIFO_DEPTH = 8;

   // Throughput ceilings (kbit/s) and page-mode cycle times (ns)
   localparam int FAST_KBPS = 8820;
   localparam int SLOW_KBPS = 6100;
   localparam int FAST_PAGE_NS = 85;
   localparam int SLOW_PAGE_NS = 120;
   localparam int FAST_RATE_CYC = (CLK_MHZ * 1000 + FAST_KBPS - 1) / FAST_KBPS;
   localparam int SLOW_RATE_CYC = (CLK_MHZ * 1000 + SLOW_KBPS - 1) / SLOW_KBPS;
   localparam int FAST_PAGE_CYC = (FAST_PAGE_NS * CLK_MHZ + 999) / 1000;
   localparam int SLOW_PAGE_CYC = (SLOW_PAGE_NS * CLK_MHZ + 999) / 1000;
   localparam int FAST_SLOT_CYC = FAST_RATE_CYC > FAST_PAGE_CYC ? FAST_RATE_CYC : FAST_PAGE_CYC;
   localparam int SLOW_SLOT_CYC = SLOW_RATE_CYC > SLOW_PAGE_CYC ? SLOW_RATE_CYC : SLOW_PAGE_CYC;
   localparam int FAST_CASL_CYC = FAST_SLOT_CYC / 2;
   localparam int SLOW_CASL_CYC = SLOW_SLOT_CYC / 2;

   // Strobe spacing (least times, rounded up)
   localparam int T_RCD_NS = 60;
   localparam int T_RP_NS = 70;
   localparam int T_RAS_NS = 100;
   localparam int T_CSR_NS = 10;
   localparam int SRAM_ACC_NS = 100;
   localparam int RCD_CYC = (T_RCD_NS * CLK_MHZ + 999) / 1000;
   localparam int RP_CYC = (T_RP_NS * CLK_MHZ + 999) / 1000;
   localparam int RAS_CYC = (T_RAS_NS * CLK_MHZ + 999) / 1000;
   localparam int CSR_CYC = (T_CSR_NS * CLK_MHZ + 999) / 1000;
   localparam int SRAM_WR_CYC = (SRAM_ACC_NS * CLK_MHZ + 999) / 1000;

   // Refresh interval (longest time, rounded down)
   localparam int REFRESH_NS = 15600;
   localparam int REFRESH_CYC = REFRESH_NS * CLK_MHZ / 1000;
   localparam int RFSH_W = 11;
   localparam int CNT_W = 5;

   // Engine states, Gray along the access path except from ST_PRE back to ST_IDLE
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0, ST_RAS = 3'h1, ST_CASL = 3'h3, ST_CASH = 3'h2,
      ST_PRE = 3'h6, ST_RFC = 3'h7, ST_RFR = 3'h5
   } ttmi_state_t;

   // Owner of the current memory cycle
   typedef enum logic [1:0] {
      SRC_RFSH = 2'h0, SRC_DISP = 2'h1, SRC_ACQ = 2'h2, SRC_CPU = 2'h3
   } ttmi_src_t;
endpackage

// file: ttmi_sram_adapter.sv
/*
 SRAM adapter: turns the bit-serial, row/column multiplexed memory cycles
 of the engine into byte-wide accesses of an asynchronous SRAM.
 Assumes the engine holds row and column stable for a whole byte and
 steps the column low bits 0..7 in order; SRAM output enable is tied on.
*/
`timescale 1ns/1ps
module ttmi_sram_adapter (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [ttmi_pkg::MADDR_W-1:0] row,
   input wire logic [ttmi_pkg::MADDR_W-1:0] col,
   input wire logic bit_strobe,
   input wire logic we,
   input wire logic wbit,
   input wire logic wr_pulse,
   input wire logic [ttmi_pkg::SRAM_DQ_W-1:0] din,
   output logic rd_bit,
   output logic [ttmi_pkg::BADDR_W-1:0] addr,
   output logic [ttmi_pkg::SRAM_DQ_W-1:0] dout,
   output logic dq_oe_n,
   output logic we_n
);
   import ttmi_pkg::*;

   logic [SRAM_DQ_W-1:0] rd_byte_ff;
   logic [SRAM_DQ_W-1:0] wr_shift_ff;
   logic [2:0] bit_idx;

   // Flat byte address from the two address halves
   assign addr = {row, col[MADDR_W-1:3]};
   assign bit_idx = col[2:0];

   // Whole byte read on the first bit, served bit by bit after
   assign rd_bit = (bit_idx == 3'h0) ? din[0] : rd_byte_ff[bit_idx];

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rd_byte_ff <= '0;
      end else if (bit_strobe && !we && bit_idx == 3'h0) begin
         rd_byte_ff <= din;
      end
   end

   // Serial write bits gathered LSB first into one byte
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wr_shift_ff <= '0;
      end else if (bit_strobe && we) begin
         wr_shift_ff <= {wbit, wr_shift_ff[SRAM_DQ_W-1:1]};
      end
   end

   // One write strobe per byte, stretched to the SRAM access time
   assign dout = wr_shift_ff;
   assign dq_oe_n = !wr_pulse;
   assign we_n = !wr_pulse;
endmodule

// file: ttmi_top.sv
/*
 Teletext memory interface: arbitrates CPU, acquisition and display
 clients onto one external 1-bit page-mode DRAM, or a byte-wide SRAM
 through the adapter, with built-in refresh and fast/slow timing.
 Assumes all client inputs are synchronous to clk_sys and that the mode
 inputs come from the control-bus command decoder.
*/
`timescale 1ns/1ps
module ttmi_top #(
   parameter int FIFO_DEPTH = ttmi_pkg::ACQ_FIFO_DEPTH
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic slow_mode,
   input wire logic sram_mode,
   input wire logic cpu_req,
   input wire logic cpu_we,
   input wire logic [ttmi_pkg::BADDR_W-1:0] cpu_addr,
   input wire logic [7:0] cpu_wdata,
   output logic cpu_ack,
   output logic [7:0] cpu_rdata,
   input wire logic acq_valid,
   output logic acq_ready,
   input wire logic [ttmi_pkg::BADDR_W-1:0] acq_addr,
   input wire logic [7:0] acq_data,
   input wire logic acq_mac,
   input wire logic disp_active,
   input wire logic disp_req,
   input wire logic [ttmi_pkg::BADDR_W-1:0] disp_addr,
   output logic disp_ack,
   output logic [7:0] disp_rdata,
   output logic [ttmi_pkg::BADDR_W-1:0] mem_addr,
   output logic mem_we_n,
   output logic pin_data_o,
   input wire logic pin_data_i,
   output logic pin_data_oe_n,
   output logic pin_ras_o,
   input wire logic pin_ras_i,
   output logic pin_ras_oe_n,
   output logic pin_cas_o,
   input wire logic pin_cas_i,
   output logic pin_cas_oe_n,
   output logic [4:0] sram_dq_o,
   input wire logic [4:0] sram_dq_i,
   output logic sram_dq_oe_n
);
   import ttmi_pkg::*;

   localparam int FW = BADDR_W + 8;

   logic rst_meta_ff;
   logic rst_n_ff;
   ttmi_state_t state_ff;
   ttmi_state_t nxt_state;
   ttmi_src_t src_ff;
   ttmi_src_t nxt_src;
   logic grant;
   logic slow_ff;
   logic sram_ff;
   logic we_ff;
   logic [BADDR_W-1:0] baddr_ff;
   logic [7:0] wdata_ff;
   logic [7:0] rbyte_ff;
   logic [2:0] bit_ff;
   logic [CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] limit;
   logic cnt_done;
   logic [RFSH_W-1:0] rfsh_cnt_ff;
   logic rfsh_pend_ff;
   logic rfsh_start;
   logic cpu_ack_ff;
   logic disp_ack_ff;
   logic [7:0] cpu_rdata_ff;
   logic [7:0] disp_rdata_ff;
   logic acq_allowed;
   logic fq_valid;
   logic fq_ready;
   logic [FW-1:0] fq_data;
   logic [MADDR_W-1:0] row;
   logic [MADDR_W-1:0] col;
   logic rd_bit;
   logic bit_strobe;
   logic sram_wr;
   logic [BADDR_W-1:0] ad_addr;
   logic [SRAM_DQ_W-1:0] ad_dout;
   logic [SRAM_DQ_W-1:0] ad_din;
   logic ad_oe_n;
   logic ad_we_n;
   logic ras_on;
   logic cas_on;

   if (FIFO_DEPTH < 2) begin : g_chk
      $error("ttmi_top: FIFO_DEPTH must be at least 2");
   end

   // Reset release through two flip-flops
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rst_meta_ff <= 1'b0;
         rst_n_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n_ff <= rst_meta_ff;
      end
   end

   // Acquisition writes are buffered so the slicer can run ahead
   ttmi_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_acq_fifo (
      .clk_sys(clk_sys),
      .rst_n(rst_n_ff),
      .in_valid(acq_valid),
      .in_ready(acq_ready),
      .in_data({acq_addr, acq_data}),
      .out_valid(fq_valid),
      .out_ready(fq_ready),
      .out_data(fq_data)
   );

   // Slow mode holds VBI lines back while display runs; MAC packets pass
   assign acq_allowed = !(slow_ff && disp_active && !acq_mac);

   // Fixed priority: refresh, display, slicer, CPU
   always_comb begin
      nxt_src = SRC_CPU;
      grant = 1'b0;
      if (state_ff == ST_IDLE && !cpu_ack_ff && !disp_ack_ff) begin
         if (rfsh_pend_ff) begin
            nxt_src = SRC_RFSH;
            grant = 1'b1;
         end else if (disp_req) begin
            nxt_src = SRC_DISP;
            grant = 1'b1;
         end else if (fq_valid && acq_allowed) begin
            nxt_src = SRC_ACQ;
            grant = 1'b1;
         end else if (cpu_req) begin
            nxt_src = SRC_CPU;
            grant = 1'b1;
         end
      end
   end
   assign fq_ready = grant && nxt_src == SRC_ACQ;
   assign rfsh_start = grant && nxt_src == SRC_RFSH;

   // Refresh timer; a new request wins over the clear
   always_ff @(posedge clk_sys or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         rfsh_cnt_ff <= '0;
         rfsh_pend_ff <= 1'b0;
      end else begin
         if (rfsh_cnt_ff == RFSH_W'(REFRESH_CYC - 1)) begin
            rfsh_cnt_ff <= '0;
            rfsh_pend_ff <= 1'b1;
         end else begin
            rfsh_cnt_ff <= rfsh_cnt_ff + 1'b1;
            if (rfsh_start) begin
               rfsh_pend_ff <= 1'b0;
            end
         end
      end
   end

   // Phase length of the current state, by mode
   always_comb begin
      limit = CNT_W'(1);
      case (state_ff)
         ST_RAS: limit = CNT_W'(RCD_CYC);
         ST_CASL: limit = slow_ff ? CNT_W'(SLOW_CASL_CYC) : CNT_W'(FAST_CASL_CYC);
         ST_CASH: limit = slow_ff ? CNT_W'(SLOW_SLOT_CYC - SLOW_CASL_CYC)
                                  : CNT_W'(FAST_SLOT_CYC - FAST_CASL_CYC);
         ST_PRE: limit = (sram_ff && we_ff) ? CNT_W'(SRAM_WR_CYC) : CNT_W'(RP_CYC);
         ST_RFC: limit = CNT_W'(CSR_CYC);
         ST_RFR: limit = CNT_W'(RAS_CYC);
         default: limit = CNT_W'(1);
      endcase
   end
   assign cnt_done = cnt_ff == limit - 1'b1;

   // Access sequence: row, eight column bits in one page, precharge
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (grant) begin
               nxt_state = (nxt_src == SRC_RFSH) ? ST_RFC : ST_RAS;
            end
         end
         ST_RAS: if (cnt_done) nxt_state = ST_CASL;
         ST_CASL: if (cnt_done) nxt_state = ST_CASH;
         ST_CASH: begin
            if (cnt_done) begin
               nxt_state = (bit_ff == 3'h7) ? ST_PRE : ST_CASL;
            end
         end
         ST_RFC: if (cnt_done) nxt_state = ST_RFR;
         ST_RFR: if (cnt_done) nxt_state = ST_PRE;
         ST_PRE: if (cnt_done) nxt_state = ST_IDLE;
         default: nxt_state = ST_IDLE;
      endcase
   end

   // State and phase counter
   always_ff @(posedge clk_sys or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         state_ff <= ST_IDLE;
         cnt_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= (nxt_state != state_ff) ? '0 : cnt_ff + 1'b1;
      end
   end

   // Request capture; mode switches take effect only between accesses
   always_ff @(posedge clk_sys or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         src_ff <= SRC_CPU;
         we_ff <= 1'b0;
         baddr_ff <= '0;
         wdata_ff <= '0;
         slow_ff <= 1'b0;
         sram_ff <= 1'b0;
      end else if (state_ff == ST_IDLE) begin
         slow_ff <= slow_mode;
         sram_ff <= sram_mode;
         if (grant) begin
            src_ff <= nxt_src;
            case (nxt_src)
               SRC_DISP: begin
                  we_ff <= 1'b0;
                  baddr_ff <= disp_addr;
               end
               SRC_ACQ: begin
                  we_ff <= 1'b1;
                  baddr_ff <= fq_data[FW-1:8];
                  wdata_ff <= fq_data[7:0];
               end
               SRC_CPU: begin
                  we_ff <= cpu_we;
                  baddr_ff <= cpu_addr;
                  wdata_ff <= cpu_wdata;
               end
               default: we_ff <= 1'b0;
            endcase
         end
      end
   end

   // Bit index within the byte and read assembly
   assign bit_strobe = state_ff == ST_CASL && cnt_done && src_ff != SRC_RFSH;
   always_ff @(posedge clk_sys or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         bit_ff <= '0;
         rbyte_ff <= '0;
      end else begin
         if (state_ff == ST_IDLE) begin
            bit_ff <= '0;
         end else if (state_ff == ST_CASH && cnt_done) begin
            bit_ff <= bit_ff + 1'b1;
         end
         if (bit_strobe && !we_ff) begin
            rbyte_ff[bit_ff] <= sram_ff ? rd_bit : pin_data_i;
         end
      end
   end

   // Completion pulse and read data to the owning client
   always_ff @(posedge clk_sys or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         cpu_ack_ff <= 1'b0;
         disp_ack_ff <= 1'b0;
         cpu_rdata_ff <= '0;
         disp_rdata_ff <= '0;
      end else begin
         cpu_ack_ff <= 1'b0;
         disp_ack_ff <= 1'b0;
         if (state_ff == ST_PRE && cnt_done) begin
            if (src_ff == SRC_CPU) begin
               cpu_ack_ff <= 1'b1;
               cpu_rdata_ff <= rbyte_ff;
            end
            if (src_ff == SRC_DISP) begin
               disp_ack_ff <= 1'b1;
               disp_rdata_ff <= rbyte_ff;
            end
         end
      end
   end
   assign cpu_ack = cpu_ack_ff;
   assign cpu_rdata = cpu_rdata_ff;
   assign disp_ack = disp_ack_ff;
   assign disp_rdata = disp_rdata_ff;

   // Bit address split: row high twelve bits, column low twelve bits
   assign row = baddr_ff[BADDR_W-1:9];
   assign col = {baddr_ff[8:0], bit_ff};

   // Byte gathered from the SRAM pins, reused strobe pins included
   assign ad_din = {sram_dq_i[4:3], pin_cas_i, pin_ras_i, pin_data_i, sram_dq_i[2:0]};
   assign sram_wr = sram_ff && we_ff && state_ff == ST_PRE && src_ff != SRC_RFSH;

   ttmi_sram_adapter u_sram (
      .clk_sys(clk_sys),
      .rst_n(rst_n_ff),
      .row(row),
      .col(col),
      .bit_strobe(bit_strobe && sram_ff),
      .we(we_ff),
      .wbit(wdata_ff[bit_ff]),
      .wr_pulse(sram_wr),
      .din(ad_din),
      .rd_bit(rd_bit),
      .addr(ad_addr),
      .dout(ad_dout),
      .dq_oe_n(ad_oe_n),
      .we_n(ad_we_n)
   );

   // DRAM strobes: CAS before RAS for refresh, else RAS then CAS pulses
   assign ras_on = state_ff == ST_RAS || state_ff == ST_CASL || state_ff == ST_CASH
                   || state_ff == ST_RFR;
   assign cas_on = state_ff == ST_CASL || state_ff == ST_RFC || state_ff == ST_RFR;

   // Pin multiplexing between DRAM and SRAM operation
   always_comb begin
      mem_addr = '0;
      if (sram_ff) begin
         mem_addr = ad_addr;
         mem_we_n = ad_we_n;
         pin_data_o = ad_dout[3];
         pin_ras_o = ad_dout[4];
         pin_cas_o = ad_dout[5];
         pin_data_oe_n = ad_oe_n;
         pin_ras_oe_n = ad_oe_n;
         pin_cas_oe_n = ad_oe_n;
      end else begin
         if (state_ff == ST_RAS) begin
            mem_addr[MADDR_W-1:0] = row;
         end else if (state_ff == ST_CASL || state_ff == ST_CASH) begin
            mem_addr[MADDR_W-1:0] = col;
         end
         mem_we_n = !(we_ff && state_ff == ST_CASL && src_ff != SRC_RFSH);
         pin_data_o = wdata_ff[bit_ff];
         pin_data_oe_n = !(we_ff && state_ff == ST_CASL && src_ff != SRC_RFSH);
         pin_ras_o = !ras_on;
         pin_cas_o = !cas_on;
         pin_ras_oe_n = 1'b0;
         pin_cas_oe_n = 1'b0;
      end
   end
   assign sram_dq_o = {ad_dout[7:6], ad_dout[2:0]};
   assign sram_dq_oe_n = sram_ff ? ad_oe_n : 1'b1;
endmodule
